/* frg_group_mem.sv */
// Word store holding the forty registers of the group
`timescale 1ns/10ps
module frg_group_mem
  import frg_pkg::*;
(
  input wire logic clk_in,    // System clock
  input wire logic resetn_in, // Async reset, active low
  frg_mem_if.mem   port       // Write and read channel
);
  typedef struct packed {
    logic [FRG_NUM_WORDS-1:0][15:0] word;
    logic [15:0]                    rd_data;
  } frg_mem_state_t;

  frg_mem_state_t s;
  frg_mem_state_t n;

  // Write one word, read one word a cycle later
  always_comb begin
    n = s;
    if (port.wr_en && (port.wr_idx <= FRG_IDX_LAST)) begin
      n.word[port.wr_idx] = port.wr_data;
    end
    // Out of range index reads zero rather than wrapping
    n.rd_data = (port.rd_idx <= FRG_IDX_LAST) ? s.word[port.rd_idx]
                                              : 16'h0000;
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign port.rd_data = s.rd_data;
endmodule

/* frg_group_top.sv */
// Register grouping: control registers, copy sequencer and read path
`timescale 1ns/10ps
module frg_group_top #(
  parameter int unsigned REFRESH_CYCLES = frg_pkg::FRG_REFRESH_CYCLES
) (
  input  wire logic        REF_CLK_IN,       // System clock, 125 MHz
  input  wire logic        RESETN_IN,        // Async reset, active low
  input  wire logic        REG_WR_IN,        // Register write strobe
  input  wire logic        REG_RD_IN,        // Register read strobe
  input  wire logic [15:0] REG_ADDR_IN,      // Register number
  input  wire logic [15:0] REG_WDATA_IN,     // Write data
  input  wire logic [15:0] BATTERY_RAW_IN,   // Battery voltage, integer
  input  wire logic [15:0] CONTRACT_HOUR_IN, // Contract hour, integer
  input  wire logic [2:0]  FORCE_FLAGS_IN,   // Forced: temp, static, diff
  input  wire logic [frg_pkg::FRG_NUM_FLOATS-1:0][31:0]
                           MEAS_FLOAT_IN,    // Float values, slot order
  output logic      [15:0] REG_RDATA_OUT,    // Read data
  output logic             REG_RVALID_OUT,   // Read data valid pulse
  output logic      [15:0] GROUP_STATE_OUT   // Current status code
);
  import frg_pkg::*;

  typedef struct packed {
    logic [15:0] base;
    logic [15:0] enable;
    logic [15:0] status;
    frg_seq_t    seq;
    logic [5:0]  idx;
    logic [16:0] gap;
    logic [15:0] low;
    logic        rd_pend;
    frg_rdsel_t  rd_sel;
    logic [15:0] rd_ctl;
    logic [15:0] rdata;
    logic        rvalid;
  } frg_state_t;

  frg_state_t  s;
  frg_state_t  n;
  frg_mem_if   grp();
  logic [4:0]  slot;
  logic [31:0] slot_val;
  logic [15:0] slot_low;
  logic [15:0] force_sum;
  logic [15:0] grp_end;
  logic        grp_hit;

  // Position of a float slot within the measured input array
  function automatic logic [4:0] frg_float_index(input logic [4:0] k);
    if (k < FRG_SLOT_FORCE) begin
      return k - 5'h01;
    end
    if (k < FRG_SLOT_HOUR) begin
      return k - 5'h02;
    end
    return k - 5'h03;
  endfunction

  // Force flags as a weighted decimal sum
  always_comb begin
    force_sum = (FORCE_FLAGS_IN[0] ? FRG_FORCE_DP_W : 16'h0000)
              + (FORCE_FLAGS_IN[1] ? FRG_FORCE_SP_W : 16'h0000)
              + (FORCE_FLAGS_IN[2] ? FRG_FORCE_TEMP_W : 16'h0000);
  end

  // Value of the slot being copied
  always_comb begin
    slot = s.idx[5:1];
    case (slot)
      FRG_SLOT_BATT: begin
        slot_val = frg_u16_to_float(BATTERY_RAW_IN);
      end
      FRG_SLOT_FORCE: begin
        slot_val = frg_u16_to_float(force_sum);
      end
      FRG_SLOT_HOUR: begin
        slot_val = frg_u16_to_float(CONTRACT_HOUR_IN);
      end
      default: begin
        // Measured, calculated and configured floats in order
        slot_val = MEAS_FLOAT_IN[frg_float_index(slot)];
      end
    endcase
    slot_low = slot_val[15:0];
  end

  // Group span and host hit test
  always_comb begin
    grp_end = s.base + FRG_GROUP_LAST;
    // Gated on status so a bad start never exposes the store
    grp_hit = (s.status == FRG_STATUS_ON) &&
              (REG_ADDR_IN >= s.base) && (REG_ADDR_IN <= grp_end);
  end

  // Channel to the word store
  assign grp.wr_en   = (s.seq == FRG_SEQ_COPY) &&
                       (s.status == FRG_STATUS_ON);
  assign grp.wr_idx  = s.idx;
  // High word goes first, to the lower register of the pair
  assign grp.wr_data = s.idx[0] ? s.low : slot_val[31:16];
  assign grp.rd_idx  = 6'(REG_ADDR_IN - s.base);

  // Next state: control writes, status, sequencer, read pipeline
  always_comb begin
    n = s;
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        FRG_ADDR_BASE: begin
          n.base = REG_WDATA_IN;
        end
        FRG_ADDR_ENABLE: begin
          n.enable = REG_WDATA_IN;
        end
        default: begin
          // Status and group registers are not host writable
        end
      endcase
    end
    // Evaluated on the new settings, so feedback is immediate
    n.status = frg_eval_status(n.base, n.enable);

    case (s.seq)
      FRG_SEQ_IDLE: begin
        if (n.status != FRG_STATUS_ON) begin
          // Restart promptly on the next valid enable
          n.gap = 17'h00000;
        end else if (s.gap == 17'h00000) begin
          n.seq = FRG_SEQ_COPY;
          n.idx = 6'h00;
        end else begin
          n.gap = s.gap - 17'h00001;
        end
      end
      FRG_SEQ_COPY: begin
        if ((s.status != FRG_STATUS_ON) ||
            (n.status != FRG_STATUS_ON)) begin
          n.seq = FRG_SEQ_IDLE;
          n.gap = 17'h00000;
        end else begin
          if (!s.idx[0]) begin
            // Hold low half so both words come from one sample
            n.low = slot_low;
          end
          if (s.idx == FRG_IDX_LAST) begin
            n.seq = FRG_SEQ_IDLE;
            n.gap = 17'(REFRESH_CYCLES - 1);
          end else begin
            n.idx = s.idx + 6'h01;
          end
        end
      end
      default: begin
        n.seq = FRG_SEQ_IDLE;
      end
    endcase

    // Read stage one: decode and capture control values
    n.rd_pend = REG_RD_IN;
    n.rd_sel  = FRG_RD_ZERO;
    n.rd_ctl  = 16'h0000;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        FRG_ADDR_BASE: begin
          n.rd_sel = FRG_RD_CTL;
          n.rd_ctl = s.base;
        end
        FRG_ADDR_ENABLE: begin
          n.rd_sel = FRG_RD_CTL;
          n.rd_ctl = s.enable;
        end
        FRG_ADDR_STATUS: begin
          n.rd_sel = FRG_RD_CTL;
          n.rd_ctl = s.status;
        end
        default: begin
          // Whole group readable as one consecutive block
          n.rd_sel = grp_hit ? FRG_RD_GRP : FRG_RD_ZERO;
        end
      endcase
    end

    // Read stage two: store data arrives one cycle after the index
    n.rvalid = s.rd_pend;
    if (s.rd_pend) begin
      case (s.rd_sel)
        FRG_RD_GRP: begin
          n.rdata = grp.rd_data;
        end
        FRG_RD_CTL: begin
          n.rdata = s.rd_ctl;
        end
        default: begin
          n.rdata = 16'h0000;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s <= '{base: FRG_BASE_RESET, enable: FRG_ENABLE_RESET,
             status: FRG_STATUS_OFF, seq: FRG_SEQ_IDLE, idx: 6'h00,
             gap: 17'h00000, low: 16'h0000, rd_pend: 1'b0,
             rd_sel: FRG_RD_ZERO, rd_ctl: 16'h0000, rdata: 16'h0000,
             rvalid: 1'b0};
    end else begin
      s <= n;
    end
  end

  // Word store
  frg_group_mem u_mem (
    .clk_in    (REF_CLK_IN),
    .resetn_in (RESETN_IN),
    .port      (grp.mem)
  );

  // Outputs straight from the state register
  assign REG_RDATA_OUT   = s.rdata;
  assign REG_RVALID_OUT  = s.rvalid;
  assign GROUP_STATE_OUT = s.status;

  // Disabled group reports off whatever the start holds
  status_off_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      (s.enable != FRG_ENABLE_ON) |-> (s.status == FRG_STATUS_OFF))
    else $error("status not off while disabled");

  // Active status only for an accepted start
  accept_range_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      (s.status == FRG_STATUS_ON) |->
        ((frg_in(s.base, FRG_INSP_LO, FRG_IN_OK_HI) ||
          frg_in(s.base, FRG_HOLD_OK_LO, FRG_HOLD_OK_HI)) &&
         !frg_ovl(s.base, grp_end, FRG_RSV2_LO, FRG_RSV2_HI)))
    else $error("status on for a start outside accepted ranges");

  // Start near the identifier block
  id_overlap_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      ((s.enable == FRG_ENABLE_ON) && (s.base > FRG_IN_OK_HI) &&
       (s.base <= FRG_ID_HI)) |-> (s.status == FRG_STATUS_ID_OVL))
    else $error("identifier overlap not reported");

  // Start in the low reserved holding block
  rsv_overlap_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      ((s.enable == FRG_ENABLE_ON) &&
       frg_in(s.base, FRG_RSV1_LO, FRG_RSV1_HI))
        |-> (s.status == FRG_STATUS_RSV))
    else $error("reserved overlap not reported");

  // Store written only while active and enabled
  write_gate_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      grp.wr_en |-> ((GROUP_STATE_OUT == FRG_STATUS_ON) &&
                     (s.enable == FRG_ENABLE_ON)))
    else $error("group written while status not on");

  // Status follows an enable write on the next edge
  immediate_status_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      (REG_WR_IN && (REG_ADDR_IN == FRG_ADDR_ENABLE)) |=>
        ((s.enable == $past(REG_WDATA_IN)) &&
         (s.status == frg_eval_status(s.base, $past(REG_WDATA_IN)))))
    else $error("status not updated after enable write");

  // Writing zero to enable stops copying at once
  enable_off_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      (REG_WR_IN && (REG_ADDR_IN == FRG_ADDR_ENABLE) &&
       (REG_WDATA_IN == 16'h0000)) |=> (!grp.wr_en)[*2])
    else $error("copying continued after disable");

  // Low word follows its high word in the next register
  word_pair_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      (grp.wr_en && !s.idx[0]) |=>
        (!grp.wr_en || ((s.idx == $past(s.idx) + 6'h01) &&
                        (grp.wr_data == $past(slot_low)))))
    else $error("float words written out of order");

  // Sweep starts soon after the group turns active
  sweep_start_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      ((s.status == FRG_STATUS_ON) &&
       ($past(s.status) != FRG_STATUS_ON)) |-> ##[1:2] grp.wr_en)
    else $error("copy sweep did not start");

  // Force sum of static and temperature is 110.0
  force_sum_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      ((slot == FRG_SLOT_FORCE) && (FORCE_FLAGS_IN == 3'h6))
        |-> (slot_val == 32'h42dc0000))
    else $error("force flag sum wrong");

  // Every read answered two edges later
  read_answer_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      REG_RD_IN |-> ##2 REG_RVALID_OUT)
    else $error("read not answered");

  // Start past the holding range lands in reserved space
  rsv_high_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      ((s.enable == FRG_ENABLE_ON) && (s.base > FRG_HOLD_OK_HI) &&
       (s.base <= FRG_RSV3_HI)) |-> (s.status == FRG_STATUS_RSV))
    else $error("high reserved overlap not reported");

  // Start below the input space is invalid
  invalid_start_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      ((s.enable == FRG_ENABLE_ON) && (s.base < FRG_INSP_LO))
        |-> (s.status == FRG_STATUS_BAD))
    else $error("invalid start not reported");

  // Group reads give zero unless the group is active
  closed_read_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      (REG_RD_IN && (s.status != FRG_STATUS_ON) &&
       ((REG_ADDR_IN < FRG_ADDR_BASE) || (REG_ADDR_IN > FRG_ADDR_STATUS)))
        |-> ##2 (REG_RDATA_OUT == 16'h0000))
    else $error("closed group returned data");

  // Status read returns the code held at the request edge
  status_read_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      (REG_RD_IN && (REG_ADDR_IN == FRG_ADDR_STATUS))
        |-> ##2 (REG_RDATA_OUT == $past(s.status, 2)))
    else $error("status read returned wrong code");

  // A finished sweep pauses before the next one
  refresh_gap_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      (grp.wr_en && (s.idx == FRG_IDX_LAST)) |=> !grp.wr_en)
    else $error("sweep restarted without a pause");

  // Contract hour nine becomes the float 9.0
  hour_float_a:
    assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      ((slot == FRG_SLOT_HOUR) && (CONTRACT_HOUR_IN == 16'h0009))
        |-> (slot_val == 32'h41100000))
    else $error("contract hour conversion wrong");
endmodule

/* frg_host_model.sv */
// Behavioural host that configures the grouping and reads registers
`timescale 1ns/10ps
module frg_host_model
  import frg_pkg::*;
(
  input  wire logic        clk_in,    // System clock
  output logic             wr_out,    // Write strobe
  output logic             rd_out,    // Read strobe
  output logic      [15:0] addr_out,  // Register number
  output logic      [15:0] wdata_out, // Write data
  input  wire logic [15:0] rdata_in,  // Read data
  input  wire logic        rvalid_in  // Read answer valid
);
  // Idle strobes low from time zero
  initial begin
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = 16'h0000;
    wdata_out = 16'h0000;
  end

  // One write, held for exactly one taking edge
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_out    <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a; // Released lines must not keep the old value
    wdata_out <= ~d;
  endtask

  // Start goes in before enable, or the status would judge stale start
  task automatic place(input logic [15:0] s, input logic [15:0] en);
    wr_reg(FRG_ADDR_BASE, s);
    wr_reg(FRG_ADDR_ENABLE, en);
  endtask

  // One read; lat counts falling edges until the answer, 0 on timeout
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d,
                        output int lat);
    @(posedge clk_in);
    rd_out   <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    lat = 0;
    d   = 16'h0000;
    for (int i = 1; i <= 8 && lat == 0; i++) begin
      @(negedge clk_in);
      if (rvalid_in === 1'b1) begin
        lat = i;
        d   = rdata_in;
      end
    end
  endtask
endmodule

/* frg_mem_if.sv */
// Write and read channel between the grouping logic and its word store
`timescale 1ns/10ps
interface frg_mem_if;
  logic        wr_en;
  logic [5:0]  wr_idx;
  logic [15:0] wr_data;
  logic [5:0]  rd_idx;
  logic [15:0] rd_data;

  modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport mem  (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

/* frg_pkg.sv */
// Constants, types and helpers for the flow register grouping block
// Summary of operation
// - Gather scattered flow data into one group
// - Group sits in input or holding space
// - Floats, high word at lower register
// - Battery voltage, contract hour converted to float
// - Twenty slots in fixed order
// - Force flags summed as 1, 10, 100
// - Slots five to sixteen carry calculated values
// - Slots seventeen to nineteen carry configured values
// - Accept start only inside allowed ranges
// - Enable 1 turns copying on, 0 off
// - Status 0 off, 1 copying, 2 invalid
// - Status 3 on reserved holding overlap
// - Status 4 on identifier range overlap
// - Group written only while status is 1
// - Status updates immediately after a write
package frg_pkg;

  // Control register addresses
  localparam logic [15:0] FRG_ADDR_BASE   = 16'hbd88;
  localparam logic [15:0] FRG_ADDR_ENABLE = 16'hbd89;
  localparam logic [15:0] FRG_ADDR_STATUS = 16'hbd8a;

  // Values after reset
  localparam logic [15:0] FRG_BASE_RESET   = 16'h0000;
  localparam logic [15:0] FRG_ENABLE_RESET = 16'h0000;

  // Enable and status codes
  localparam logic [15:0] FRG_ENABLE_ON     = 16'h0001;
  localparam logic [15:0] FRG_STATUS_OFF    = 16'h0000;
  localparam logic [15:0] FRG_STATUS_ON     = 16'h0001;
  localparam logic [15:0] FRG_STATUS_BAD    = 16'h0002;
  localparam logic [15:0] FRG_STATUS_RSV    = 16'h0003;
  localparam logic [15:0] FRG_STATUS_ID_OVL = 16'h0004;

  // Address spaces and accepted start ranges
  localparam logic [15:0] FRG_INSP_LO    = 16'h7531;
  localparam logic [15:0] FRG_IN_OK_HI   = 16'h9b50;
  localparam logic [15:0] FRG_HOLD_OK_LO = 16'h9e35;
  localparam logic [15:0] FRG_HOLD_OK_HI = 16'hb964;
  localparam logic [15:0] FRG_ID_LO      = 16'h9b78;
  localparam logic [15:0] FRG_ID_HI      = 16'h9c3f;
  localparam logic [15:0] FRG_RSV1_LO    = 16'h9c41;
  localparam logic [15:0] FRG_RSV1_HI    = 16'h9e34;
  localparam logic [15:0] FRG_RSV2_LO    = 16'ha8ac;
  localparam logic [15:0] FRG_RSV2_HI    = 16'hab17;
  localparam logic [15:0] FRG_RSV3_LO    = 16'hb98c;
  localparam logic [15:0] FRG_RSV3_HI    = 16'hc34f;

  // Group geometry: twenty floats, two words each
  localparam int          FRG_NUM_SLOTS  = 20;
  localparam int          FRG_NUM_FLOATS = 17;
  localparam int          FRG_NUM_WORDS  = 40;
  localparam logic [15:0] FRG_GROUP_LAST = 16'h0027;
  localparam logic [5:0]  FRG_IDX_LAST   = 6'h27;
  localparam logic [4:0]  FRG_SLOT_BATT  = 5'h00;
  localparam logic [4:0]  FRG_SLOT_FORCE = 5'h04;
  localparam logic [4:0]  FRG_SLOT_HOUR  = 5'h12;

  // Force flag weights
  localparam logic [15:0] FRG_FORCE_DP_W   = 16'h0001;
  localparam logic [15:0] FRG_FORCE_SP_W   = 16'h000a;
  localparam logic [15:0] FRG_FORCE_TEMP_W = 16'h0064;

  // Refresh period
  localparam int FRG_CLK_MHZ           = 125;
  localparam int FRG_REFRESH_PERIOD_US = 1000;
  localparam int FRG_REFRESH_CYCLES    = FRG_REFRESH_PERIOD_US * FRG_CLK_MHZ;

  typedef enum logic {FRG_SEQ_IDLE, FRG_SEQ_COPY} frg_seq_t;
  typedef enum logic [1:0] {FRG_RD_ZERO, FRG_RD_CTL, FRG_RD_GRP} frg_rdsel_t;

  // Inclusive range test
  function automatic logic frg_in(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Overlap of span [s,e] with [lo,hi]
  function automatic logic frg_ovl(input logic [15:0] s,
                                   input logic [15:0] e,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (s <= hi) && (e >= lo);
  endfunction

  // Unsigned word to single precision float
  function automatic logic [31:0] frg_u16_to_float(input logic [15:0] v);
    logic [4:0]  p;
    logic [38:0] sh;
    logic [7:0]  ex;
    p = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        p = 5'(i);
      end
    end
    sh = {23'h0, v} << (5'h17 - p);
    ex = 8'h7f + {3'h0, p};
    if (v == 16'h0000) begin
      return 32'h00000000;
    end
    return {1'b0, ex, sh[22:0]};
  endfunction

  // Status code from start address and enable
  function automatic logic [15:0] frg_eval_status(input logic [15:0] b,
                                                  input logic [15:0] en);
    logic [15:0] e;
    e = b + FRG_GROUP_LAST;
    if (en != FRG_ENABLE_ON) begin
      return FRG_STATUS_OFF;
    end
    if (!frg_in(b, FRG_INSP_LO, FRG_ID_HI) &&
        !frg_in(b, FRG_RSV1_LO, FRG_RSV3_HI)) begin
      return FRG_STATUS_BAD;
    end
    if (frg_ovl(b, e, FRG_ID_LO, FRG_ID_HI)) begin
      return FRG_STATUS_ID_OVL;
    end
    if (frg_ovl(b, e, FRG_RSV1_LO, FRG_RSV1_HI) ||
        frg_ovl(b, e, FRG_RSV2_LO, FRG_RSV2_HI) ||
        frg_ovl(b, e, FRG_RSV3_LO, FRG_RSV3_HI)) begin
      return FRG_STATUS_RSV;
    end
    return FRG_STATUS_ON;
  endfunction

endpackage

/* test_flow_register_grouping.sv */
// Self-checking bench for the register grouping block
`timescale 1ns/10ps
module test_flow_register_grouping;
  import frg_pkg::*;
  logic                   clk;
  logic                   resetn;
  logic                   wr;
  logic                   rd;
  logic [15:0]            addr;
  logic [15:0]            wdata;
  logic [15:0]            batt;
  logic [15:0]            hour;
  logic [2:0]             force_flags;
  logic [16:0][31:0]      meas;
  logic [15:0]            rdata;
  logic                   rvalid;
  logic [15:0]            state;
  logic [31:0]            batt_f;
  logic [31:0]            hour_f;
  logic [31:0]            force_f;
  int                     fail_count;
  int                     checks_done;
  // Start addresses at both edges of every accepted and reserved range
  logic [15:0] st_addr [16] = '{16'h7918, 16'h7530, 16'h9b50, 16'h9b51,
    16'h9c41, 16'h9e34, 16'h9e35, 16'ha884, 16'ha885, 16'hab18,
    16'hb964, 16'hb965, 16'hc350, 16'h752f, 16'h9c40, 16'h9c3f};
  logic [15:0] st_code [16] = '{16'h0001, 16'h0002, 16'h0001, 16'h0004,
    16'h0003, 16'h0003, 16'h0001, 16'h0001, 16'h0003, 16'h0001,
    16'h0001, 16'h0003, 16'h0002, 16'h0002, 16'h0002, 16'h0004};

  // Short refresh period keeps the run brief
  frg_group_top #(.REFRESH_CYCLES(20)) dut_u (
    .REF_CLK_IN       (clk),
    .RESETN_IN        (resetn),
    .REG_WR_IN        (wr),
    .REG_RD_IN        (rd),
    .REG_ADDR_IN      (addr),
    .REG_WDATA_IN     (wdata),
    .BATTERY_RAW_IN   (batt),
    .CONTRACT_HOUR_IN (hour),
    .FORCE_FLAGS_IN   (force_flags),
    .MEAS_FLOAT_IN    (meas),
    .REG_RDATA_OUT    (rdata),
    .REG_RVALID_OUT   (rvalid),
    .GROUP_STATE_OUT  (state)
  );

  frg_host_model host_u (
    .clk_in    (clk),
    .wr_out    (wr),
    .rd_out    (rd),
    .addr_out  (addr),
    .wdata_out (wdata),
    .rdata_in  (rdata),
    .rvalid_in (rvalid)
  );

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("Checks done %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read with answer seen on exactly the second falling edge after the taking edge
  task automatic rd_chk(input logic [15:0] a, output logic [15:0] d);
    int lat;
    host_u.rd_reg(a, d, lat);
    check(32'(lat), 32'h00000002);
    if (lat == 0) results();
  endtask

  task automatic rd_eq(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd_chk(a, d);
    check({16'h0000, d}, {16'h0000, exp});
  endtask

  // Expected float of slot k from the bench's own copy of the inputs
  function automatic logic [31:0] exp_slot(input int k);
    if (k == 0) return batt_f;
    if (k == 4) return force_f;
    if (k == 18) return hour_f;
    if (k < 4) return meas[k-1];
    if (k < 18) return meas[k-2];
    return meas[16];
  endfunction

  // Whole group as one sequential sweep, high word first
  task automatic chk_group(input logic [15:0] s);
    logic [15:0] hi;
    logic [15:0] lo;
    for (int k = 0; k < 20; k++) begin
      rd_chk(s + 16'(2 * k), hi);
      rd_chk(s + 16'(2 * k + 1), lo);
      check({hi, lo}, exp_slot(k));
    end
  endtask

  task automatic t_reset();
    check({16'h0000, state}, 32'h00000000);
    rd_eq(FRG_ADDR_BASE, FRG_BASE_RESET);
    rd_eq(FRG_ADDR_ENABLE, FRG_ENABLE_RESET);
    rd_eq(FRG_ADDR_STATUS, FRG_STATUS_OFF);
    $display("test reset done");
  endtask

  // Every status code, checked on the port and through the register
  task automatic t_codes();
    for (int i = 0; i < 16; i++) begin
      host_u.place(st_addr[i], FRG_ENABLE_ON);
      @(negedge clk);
      check({16'h0000, state}, {16'h0000, st_code[i]});
      rd_eq(FRG_ADDR_STATUS, st_code[i]);
    end
    host_u.place(16'h7530, 16'h0000);
    @(negedge clk);
    check({16'h0000, state}, 32'h00000000);
    host_u.place(16'h7918, 16'h0002);
    rd_eq(FRG_ADDR_STATUS, FRG_STATUS_OFF);
    host_u.place(16'h7918, FRG_ENABLE_ON);
    host_u.wr_reg(FRG_ADDR_STATUS, 16'h0000);
    rd_eq(FRG_ADDR_STATUS, FRG_STATUS_ON);
    $display("test codes done");
  endtask

  // Group contents in input space, then in holding space
  task automatic t_data();
    host_u.place(16'h7918, FRG_ENABLE_ON);
    repeat (60) @(posedge clk);
    chk_group(16'h7918);
    rd_eq(16'h7917, 16'h0000);
    rd_eq(16'h7940, 16'h0000);
    rd_eq(16'h1234, 16'h0000);
    host_u.place(16'hab18, FRG_ENABLE_ON);
    repeat (60) @(posedge clk);
    chk_group(16'hab18);
    host_u.wr_reg(FRG_ADDR_ENABLE, 16'h0000);
    rd_eq(16'hab18, 16'h0000);
    rd_eq(FRG_ADDR_STATUS, FRG_STATUS_OFF);
    $display("test data done");
  endtask

  // Inputs change while copying; later sweeps must pick them up
  task automatic t_refresh();
    host_u.place(16'h7918, FRG_ENABLE_ON);
    repeat (60) @(posedge clk);
    batt        <= 16'h0005;
    force_flags <= 3'h7;
    meas[16]    <= 32'h40490fdb;
    batt_f  = 32'h40a00000;
    force_f = 32'h42de0000;
    repeat (140) @(posedge clk);
    chk_group(16'h7918);
    $display("test refresh done");
  endtask

  // Main sequence: reset for 16 cycles, then each scenario
  initial begin
    fail_count  = 0;
    checks_done = 0;
    resetn      = 1'b0;
    batt        = 16'h000c;
    hour        = 16'h0009;
    force_flags = 3'h6;
    batt_f      = 32'h41400000;
    hour_f      = 32'h41100000;
    force_f     = 32'h42dc0000;
    for (int i = 0; i < 17; i++) begin
      meas[i] = {16'h4100 + 16'(i), 16'ha500 + 16'(i)};
    end
    repeat (16) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_codes();
    t_data();
    t_refresh();
    results();
  end
endmodule
